// ---- core/drdec_core.sv ----
// Module: task-file register decode for proxy-for-device-1 and Sleep modes
//
// Functional notes
// - Proxy: sector number write stored when busy and data request are clear.
// - Proxy: reads of sector count and sector number return own registers.
// - Proxy: cylinder low written and read back from own register.
// - Proxy: cylinder high written and read back from own register.
// - Proxy: device/head write stored, selection re-evaluated from new DEV bit.
// - Proxy: device/head read returns own register with DEV forced to one.
// - Proxy: command latched, executed only if it is EXECUTE DEVICE DIAGNOSTICS.
// - Proxy: status reads return 00H.
// - Proxy: strobes with both chip selects asserted are ignored.
// - Sleep: device control write only updates SRST; wake only when SRST is 1.
// - Sleep without reset command: DMARQ released, all but control write ignored.
// - Sleep with reset command: DMARQ released, DEV bit captured from writes.
// - Sleep with reset command: command write ignored unless selected DEVICE RESET.
// - Sleep with reset command: status and other block reads and writes ignored.
// - Selected exactly when stored DEV bit equals own device number.
// - Both selects equal outside DMA: data released, strobes ignored.
`timescale 1ns/10ps
module drdec_core
    import drdec_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Host task-file pins
    input  wire logic        cs0_n,
    input  wire logic        cs1_n,
    input  wire logic [2:0]  da,
    input  wire logic        dior_n,
    input  wire logic        diow_n,
    input  wire logic [7:0]  dd_in,
    output logic      [7:0]  dd_out,
    output logic             dd_oe,
    output logic             dmarq_out,
    output logic             dmarq_oe,
    // Device state from the drive core
    input  wire logic        own_dev,
    input  wire logic        dev1_absent,
    input  wire logic        bsy,
    input  wire logic        drq,
    input  wire logic        dmarq_req,
    input  wire logic        in_sleep,
    input  wire logic        reset_cmd_supported,
    input  wire logic [7:0]  status_in,
    input  wire logic [7:0]  error_in,
    // Register contents and events to the drive core
    output logic      [7:0]  feature_reg,
    output logic      [7:0]  seccnt_reg,
    output logic      [7:0]  secnum_reg,
    output logic      [7:0]  cyllo_reg,
    output logic      [7:0]  cylhi_reg,
    output logic      [7:0]  devhead_reg,
    output logic      [7:0]  command_reg,
    output logic      [7:0]  devctl_reg,
    output logic             selected,
    output logic             cmd_exec,
    output logic             srst_wake,
    output logic      [1:0]  mode
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    drdec_sync_if sync_if ();

    logic [7:0] dd_meta_q;
    logic [7:0] dd_stab_q;

    drdec_pin_sync u_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .cs0_n    (cs0_n),
        .cs1_n    (cs1_n),
        .da       (da),
        .dior_n   (dior_n),
        .diow_n   (diow_n),
        .sync     (sync_if.front)
    );

    // Device number and absence flag come from another domain; the data bus from pins
    // Data takes the same two flops as the strobe path; the host sets it up before the strobe, so it has settled when used
    logic [1:0] ctl_meta_q;
    logic [1:0] ctl_meta_d;
    logic [1:0] ctl_stab_q;
    logic [1:0] ctl_stab_d;
    logic [7:0] dd_meta_d;
    logic [7:0] dd_stab_d;

    always_comb begin
        dd_meta_d  = dd_in;
        dd_stab_d  = dd_meta_q;
        ctl_meta_d = {own_dev, dev1_absent};
        ctl_stab_d = ctl_meta_q;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dd_meta_q  <= DRDEC_RST_REG;
            dd_stab_q  <= DRDEC_RST_REG;
            ctl_meta_q <= 2'h0;
            ctl_stab_q <= 2'h0;
        end else begin
            dd_meta_q  <= dd_meta_d;
            dd_stab_q  <= dd_stab_d;
            ctl_meta_q <= ctl_meta_d;
            ctl_stab_q <= ctl_stab_d;
        end
    end

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    logic        own_dev_s;
    logic        dev1_absent_s;
    logic        sel_now;
    drdec_mode_t mode_now;

    function automatic logic dev_match(input logic [7:0] dh, input logic dev);
        dev_match = (dh[DRDEC_DEV_BIT] == dev);
    endfunction

    always_comb begin
        own_dev_s     = ctl_stab_q[1];
        dev1_absent_s = ctl_stab_q[0];
        sel_now       = dev_match(devhead_reg, own_dev_s);
        // Sleep outranks proxy: a sleeping device answers only its wake paths
        if (in_sleep && reset_cmd_supported) begin
            mode_now = DRDEC_MODE_SLEEP_R;
        end else if (in_sleep) begin
            mode_now = DRDEC_MODE_SLEEP_NR;
        end else if (!own_dev_s && devhead_reg[DRDEC_DEV_BIT] && dev1_absent_s) begin
            mode_now = DRDEC_MODE_PROXY;
        end else begin
            mode_now = DRDEC_MODE_NORMAL;
        end
    end

    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic       cmd_blk;
    logic       ctl_blk;
    logic       idle_ok;
    logic [7:0] feat_d;
    logic [7:0] sc_d;
    logic [7:0] sn_d;
    logic [7:0] cl_d;
    logic [7:0] ch_d;
    logic [7:0] dh_d;
    logic [7:0] cmdr_d;
    logic [7:0] dc_d;
    logic       exec_d;
    logic       wake_d;
    logic       rd_ok;
    logic [7:0] rd_val;

    always_comb begin
        // Both selects equal means no register addressed
        cmd_blk = sync_if.cs0 & ~sync_if.cs1;
        ctl_blk = ~sync_if.cs0 & sync_if.cs1 & (sync_if.addr == DRDEC_A_DEVCTL);
        // Proxy writes while busy would race the drive core, so they are dropped
        idle_ok = ~bsy & ~drq;
        feat_d  = feature_reg;
        sc_d    = seccnt_reg;
        sn_d    = secnum_reg;
        cl_d    = cyllo_reg;
        ch_d    = cylhi_reg;
        dh_d    = devhead_reg;
        cmdr_d  = command_reg;
        dc_d    = devctl_reg;
        exec_d  = 1'b0;
        wake_d  = 1'b0;
        rd_ok   = 1'b0;
        rd_val  = DRDEC_ZERO_BYTE;

        case (mode_now)
            DRDEC_MODE_SLEEP_NR, DRDEC_MODE_SLEEP_R: begin
                if (sync_if.wr_pulse && ctl_blk) begin
                    // Only SRST of device control changes while asleep
                    dc_d[DRDEC_SRST_BIT] = dd_stab_q[DRDEC_SRST_BIT];
                    wake_d               = dd_stab_q[DRDEC_SRST_BIT];
                end
                // All reads ignored while asleep
                if (mode_now == DRDEC_MODE_SLEEP_R && sync_if.wr_pulse && cmd_blk) begin
                    if (sync_if.addr == DRDEC_A_DEVHEAD) begin
                        dh_d[DRDEC_DEV_BIT] = dd_stab_q[DRDEC_DEV_BIT];
                    end else if (sync_if.addr == DRDEC_A_CMD && sel_now && dd_stab_q == DRDEC_CMD_DRST) begin
                        cmdr_d = dd_stab_q;
                        exec_d = 1'b1;
                    end
                end
            end
            DRDEC_MODE_PROXY: begin
                if (sync_if.wr_pulse && ctl_blk && idle_ok) begin
                    dc_d   = dd_stab_q;
                    wake_d = dd_stab_q[DRDEC_SRST_BIT];
                end
                if (sync_if.rd_level && ctl_blk && idle_ok) begin
                    rd_ok = 1'b1;
                end
                if (sync_if.wr_pulse && cmd_blk && idle_ok) begin
                    if (sync_if.addr == DRDEC_A_FEAT) begin
                        feat_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_SECCNT) begin
                        sc_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_SECNUM) begin
                        sn_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_CYLLO) begin
                        cl_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_CYLHI) begin
                        ch_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_DEVHEAD) begin
                        dh_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_CMD) begin
                        cmdr_d = dd_stab_q;
                        exec_d = (dd_stab_q == DRDEC_CMD_DIAG);
                    end
                end
                if (sync_if.rd_level && cmd_blk && idle_ok && sync_if.addr != DRDEC_A_DATA) begin
                    rd_ok = 1'b1;
                    if (sync_if.addr == DRDEC_A_FEAT) begin
                        rd_val = error_in;
                    end else if (sync_if.addr == DRDEC_A_SECCNT) begin
                        rd_val = seccnt_reg;
                    end else if (sync_if.addr == DRDEC_A_SECNUM) begin
                        rd_val = secnum_reg;
                    end else if (sync_if.addr == DRDEC_A_CYLLO) begin
                        rd_val = cyllo_reg;
                    end else if (sync_if.addr == DRDEC_A_CYLHI) begin
                        rd_val = cylhi_reg;
                    end else if (sync_if.addr == DRDEC_A_DEVHEAD) begin
                        rd_val = devhead_reg | (8'h01 << DRDEC_DEV_BIT);
                    end else begin
                        rd_val = DRDEC_ZERO_BYTE;
                    end
                end
            end
            default: begin
                // Selected, non-sleep decode lives elsewhere; keep the device/head copy and, when selected, the command copy current
                if (sync_if.wr_pulse && cmd_blk && idle_ok) begin
                    if (sync_if.addr == DRDEC_A_DEVHEAD) begin
                        dh_d = dd_stab_q;
                    end else if (sync_if.addr == DRDEC_A_CMD && sel_now) begin
                        cmdr_d = dd_stab_q;
                        exec_d = 1'b1;
                    end
                end
                if (sync_if.rd_level && cmd_blk && sel_now && sync_if.addr == DRDEC_A_CMD) begin
                    rd_ok  = 1'b1;
                    rd_val = status_in;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Registers and output flops
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            feature_reg <= DRDEC_RST_REG;
            seccnt_reg  <= DRDEC_RST_SECCNT;
            secnum_reg  <= DRDEC_RST_SECNUM;
            cyllo_reg   <= DRDEC_RST_REG;
            cylhi_reg   <= DRDEC_RST_REG;
            devhead_reg <= DRDEC_RST_REG;
            command_reg <= DRDEC_RST_REG;
            devctl_reg  <= DRDEC_RST_REG;
            cmd_exec    <= 1'b0;
            srst_wake   <= 1'b0;
            selected    <= 1'b0;
            mode        <= 2'h0;
            dd_out      <= 8'h00;
            dd_oe       <= 1'b0;
            dmarq_out   <= 1'b0;
            dmarq_oe    <= 1'b0;
        end else begin
            feature_reg <= feat_d;
            seccnt_reg  <= sc_d;
            secnum_reg  <= sn_d;
            cyllo_reg   <= cl_d;
            cylhi_reg   <= ch_d;
            devhead_reg <= dh_d;
            command_reg <= cmdr_d;
            devctl_reg  <= dc_d;
            // One-cycle pulses: the drive core must take them on the edge they stand
            cmd_exec    <= exec_d;
            srst_wake   <= wake_d;
            selected    <= dev_match(dh_d, own_dev_s);
            mode        <= mode_now;
            // Read data trails the strobe by the sync delay on both edges
            dd_out      <= rd_val;
            dd_oe       <= rd_ok;
            // DMARQ released while asleep
            dmarq_out   <= dmarq_req;
            dmarq_oe    <= (mode_now == DRDEC_MODE_NORMAL) && sel_now;
        end
    end

endmodule

// ---- include/drdec_pkg.sv ----
// Package: constants and types for the task-file register decode block
package drdec_pkg;

    // Register addresses (DA2..DA0) within each chip-select block
    localparam logic [2:0] DRDEC_A_DATA    = 3'h0;
    localparam logic [2:0] DRDEC_A_FEAT    = 3'h1;
    localparam logic [2:0] DRDEC_A_SECCNT  = 3'h2;
    localparam logic [2:0] DRDEC_A_SECNUM  = 3'h3;
    localparam logic [2:0] DRDEC_A_CYLLO   = 3'h4;
    localparam logic [2:0] DRDEC_A_CYLHI   = 3'h5;
    localparam logic [2:0] DRDEC_A_DEVHEAD = 3'h6;
    localparam logic [2:0] DRDEC_A_CMD     = 3'h7;
    localparam logic [2:0] DRDEC_A_DEVCTL  = 3'h6;

    // Field positions
    localparam int DRDEC_DEV_BIT  = 4;
    localparam int DRDEC_SRST_BIT = 2;
    localparam int DRDEC_NIEN_BIT = 1;

    // Command codes
    localparam logic [7:0] DRDEC_CMD_DIAG  = 8'h90;
    localparam logic [7:0] DRDEC_CMD_DRST  = 8'h08;

    // Reset values
    localparam logic [7:0] DRDEC_RST_REG    = 8'h00;
    localparam logic [7:0] DRDEC_RST_SECCNT = 8'h01;
    localparam logic [7:0] DRDEC_RST_SECNUM = 8'h01;
    localparam logic [7:0] DRDEC_ZERO_BYTE  = 8'h00;

    // Decode modes
    typedef enum logic [1:0] {
        DRDEC_MODE_NORMAL,
        DRDEC_MODE_PROXY,
        DRDEC_MODE_SLEEP_NR,
        DRDEC_MODE_SLEEP_R
    } drdec_mode_t;

endpackage

// ---- include/drdec_sync_if.sv ----
// Interface: synchronised host strobes between the top and the pin front end
`timescale 1ns/10ps
interface drdec_sync_if;
    logic       cs0;
    logic       cs1;
    logic [2:0] addr;
    logic       rd_pulse;
    logic       wr_pulse;
    logic       rd_level;

    modport front (output cs0, output cs1, output addr, output rd_pulse, output wr_pulse, output rd_level);
    modport core  (input cs0, input cs1, input addr, input rd_pulse, input wr_pulse, input rd_level);
endinterface

// ---- core/drdec_pin_sync.sv ----
// Module: two-stage synchroniser and strobe edge detect for host pins
`timescale 1ns/10ps
module drdec_pin_sync
    import drdec_pkg::*;
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   arst_n,
    // Host pins, active low selects and strobes
    input  wire logic   cs0_n,
    input  wire logic   cs1_n,
    input  wire logic [2:0] da,
    input  wire logic   dior_n,
    input  wire logic   diow_n,
    // Synchronised view
    drdec_sync_if.front sync
);

    logic [6:0] meta_q;
    logic [6:0] meta_d;
    logic [6:0] stab_q;
    logic [6:0] stab_d;
    logic       rd_prev_q;
    logic       rd_prev_d;
    logic       wr_prev_q;
    logic       wr_prev_d;

    always_comb begin
        meta_d    = {~cs0_n, ~cs1_n, da, ~dior_n, ~diow_n};
        stab_d    = meta_q;
        rd_prev_d = stab_q[1];
        wr_prev_d = stab_q[0];
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q    <= 7'h00;
            stab_q    <= 7'h00;
            rd_prev_q <= 1'b0;
            wr_prev_q <= 1'b0;
        end else begin
            meta_q    <= meta_d;
            stab_q    <= stab_d;
            rd_prev_q <= rd_prev_d;
            wr_prev_q <= wr_prev_d;
        end
    end

    // Address follows the pins through the same two flops, not latched on a strobe edge; host holds it stable
    assign sync.cs0      = stab_q[6];
    assign sync.cs1      = stab_q[5];
    assign sync.addr     = stab_q[4:2];
    assign sync.rd_level = stab_q[1];
    assign sync.rd_pulse = stab_q[1] & ~rd_prev_q;
    assign sync.wr_pulse = stab_q[0] & ~wr_prev_q;

endmodule

// ---- verification/drdec_core_assertions.sv ----
// Checker: concurrent assertions on the decode block's ports
`timescale 1ns/10ps
module drdec_core_chk (
    // Clock, reset and pins
    input wire logic       core_clk,
    input wire logic       arst_n,
    input wire logic       cs0_n,
    input wire logic       cs1_n,
    input wire logic       dior_n,
    input wire logic       dd_oe,
    input wire logic       dmarq_oe,
    input wire logic       own_dev,
    // Registers and events
    input wire logic [7:0] devhead_reg,
    input wire logic [7:0] command_reg,
    input wire logic [7:0] devctl_reg,
    input wire logic [7:0] cyllo_reg,
    input wire logic [7:0] cylhi_reg,
    input wire logic [7:0] secnum_reg,
    input wire logic       selected,
    input wire logic       cmd_exec,
    input wire logic       srst_wake,
    input wire logic [1:0] mode
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Two cycles of mode guard against the one-cycle lag of mode
    chk_dmarq_off: assert property (mode != 2'h0 && $past(mode) != 2'h0 |-> !dmarq_oe)
        else $error("dma request driven in sleep or proxy");
    chk_diag_only: assert property (cmd_exec && mode == 2'h1 |-> command_reg == 8'h90)
        else $error("proxy executed a command other than diagnostics");
    chk_nr_no_exec: assert property (mode == 2'h2 |-> !cmd_exec)
        else $error("command executed in sleep without reset command");
    chk_drst_sel: assert property (cmd_exec && mode == 2'h3 |-> selected && command_reg == 8'h08)
        else $error("sleep command accepted without selected reset");
    chk_wake_srst: assert property (srst_wake |-> devctl_reg[2])
        else $error("wake without reset bit set");
    chk_sel_match: assert property (($stable(devhead_reg) && $stable(own_dev)) [*6] |->
        selected == (devhead_reg[4] == own_dev))
        else $error("selection does not follow device bit");
    chk_sleep_quiet: assert property (mode[1] && $past(mode[1]) |->
        !dd_oe && $stable(cyllo_reg) && $stable(cylhi_reg) && $stable(secnum_reg))
        else $error("access answered in sleep");
    // Strobe falls off the edge, so the first low sample is three edges before dd_oe is seen high
    chk_read_lag: assert property ($rose(dd_oe) |-> $past(dior_n, 4) && !$past(dior_n, 3))
        else $error("read data enable at wrong cycle");
    chk_cs_valid: assert property ($rose(dd_oe) |-> $past(cs0_n, 2) != $past(cs1_n, 2))
        else $error("data driven with invalid selects");
endmodule
bind drdec_core drdec_core_chk u_chk (.core_clk, .arst_n, .cs0_n, .cs1_n, .dior_n, .dd_oe, .dmarq_oe, .own_dev,
    .devhead_reg, .command_reg, .devctl_reg, .cyllo_reg, .cylhi_reg, .secnum_reg, .selected, .cmd_exec,
    .srst_wake, .mode);

// ---- verification/drdec_host.sv ----
// Host adapter model: task-file cycles launched at the falling edge
`timescale 1ns/10ps
module drdec_host (
    // Clock
    input wire logic       core_clk,
    // Pins to the device
    output logic           cs0_n,
    output logic           cs1_n,
    output logic     [2:0] da,
    output logic           dior_n,
    output logic           diow_n,
    output logic     [7:0] dd_in,
    // Read side
    input wire logic [7:0] dd_out,
    input wire logic       dd_oe
);
    initial begin
        cs0_n = 1'b1;
        cs1_n = 1'b1;
        da = 3'h0;
        dior_n = 1'b1;
        diow_n = 1'b1;
        dd_in = 8'hA5;
    end
    task automatic setup(input logic [1:0] cs, input logic [2:0] a);
        @(negedge core_clk);
        cs0_n = ~cs[0];
        cs1_n = ~cs[1];
        da = a;
    endtask
    task automatic idle();
        repeat (4) @(negedge core_clk);
        cs0_n = 1'b1;
        cs1_n = 1'b1;
    endtask
    // Released data shows the inverse so a stale value cannot pass
    task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [7:0] d);
        setup(cs, a);
        dd_in = d;
        repeat (3) @(negedge core_clk);
        diow_n = 1'b0;
        repeat (5) @(negedge core_clk);
        diow_n = 1'b1;
        idle();
        dd_in = ~d;
    endtask
    task automatic rd(input logic [1:0] cs, input logic [2:0] a, output logic [7:0] d, output logic oe);
        setup(cs, a);
        repeat (3) @(negedge core_clk);
        dior_n = 1'b0;
        repeat (4) @(negedge core_clk);
        d = dd_out;
        oe = dd_oe;
        dior_n = 1'b1;
        idle();
    endtask
endmodule

// ---- verification/drdec_core_tb.sv ----
// Testbench: decode checks for proxy and Sleep modes
`timescale 1ns/10ps
module drdec_core_tb
    import drdec_pkg::*;
;
    logic       core_clk = 1'b0, arst_n = 1'b0, own_dev = 1'b0, dev1_absent = 1'b1, bsy = 1'b0;
    logic       drq = 1'b0, dmarq_req = 1'b1, in_sleep = 1'b0, reset_cmd_supported = 1'b0;
    logic [7:0] status_in = 8'h50, error_in = 8'h00;
    logic       cs0_n, cs1_n, dior_n, diow_n, dd_oe, dmarq_out, dmarq_oe, selected, cmd_exec, srst_wake;
    logic [2:0] da;
    logic [1:0] mode;
    logic [7:0] dd_in, dd_out, feature_reg, seccnt_reg, secnum_reg, cyllo_reg, cylhi_reg;
    logic [7:0] devhead_reg, command_reg, devctl_reg;
    int         bad_count = 0, n_tests = 0, n_exec = 0, n_wake = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (cmd_exec === 1'b1) n_exec++;
        if (srst_wake === 1'b1) n_wake++;
    end
    drdec_core dut (.core_clk, .arst_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dd_in, .dd_out, .dd_oe,
        .dmarq_out, .dmarq_oe, .own_dev, .dev1_absent, .bsy, .drq, .dmarq_req, .in_sleep, .reset_cmd_supported,
        .status_in, .error_in, .feature_reg, .seccnt_reg, .secnum_reg, .cyllo_reg, .cylhi_reg, .devhead_reg,
        .command_reg, .devctl_reg, .selected, .cmd_exec, .srst_wake, .mode);
    drdec_host host (.core_clk, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dd_in, .dd_out, .dd_oe);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        logic [7:0] r, d;
        logic [7:0] m [2:5];
        logic [2:0] a;
        logic       oe;
        int         e;
        r = 8'($urandom(32'hEAAB));
        status_in = status_in | r;
        repeat (16) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(seccnt_reg, DRDEC_RST_SECCNT);
        chk(secnum_reg, DRDEC_RST_SECNUM);
        host.wr(2'b01, DRDEC_A_DEVHEAD, 8'h10);
        repeat (3) @(negedge core_clk);
        chk({7'h0, selected}, 8'h00);
        chk({6'h0, mode}, {6'h0, DRDEC_MODE_PROXY});
        for (int i = 0; i < 8; i++) begin
            r = 8'($urandom);
            a = 3'(2 + i % 4);
            m[a] = r;
            host.wr(2'b01, a, r);
            host.rd(2'b01, a, d, oe);
            chk(d, r);
        end
        bsy = 1'b1;
        host.wr(2'b01, DRDEC_A_SECNUM, ~m[3]);
        bsy = 1'b0;
        chk(secnum_reg, m[3]);
        host.wr(2'b11, DRDEC_A_CYLLO, ~m[4]);
        chk(cyllo_reg, m[4]);
        for (int c = 0; c < 4; c += 3) begin
            host.rd(2'(c), DRDEC_A_CYLLO, d, oe);
            chk({7'h0, oe}, 8'h00);
        end
        r = 8'($urandom) | 8'h10;
        host.wr(2'b01, DRDEC_A_DEVHEAD, r);
        host.rd(2'b01, DRDEC_A_DEVHEAD, d, oe);
        chk(d, r | 8'h10);
        host.rd(2'b01, DRDEC_A_CMD, d, oe);
        chk(d, DRDEC_ZERO_BYTE);
        e = n_exec;
        host.wr(2'b01, DRDEC_A_CMD, DRDEC_CMD_DIAG);
        chk(8'(n_exec - e), 8'h01);
        r = 8'($urandom_range(8'h8F));
        host.wr(2'b01, DRDEC_A_CMD, r);
        chk(command_reg, r);
        chk(8'(n_exec - e), 8'h01);
        r = 8'($urandom);
        host.wr(2'b01, DRDEC_A_FEAT, r);
        chk(feature_reg, r);
        host.wr(2'b01, DRDEC_A_DEVHEAD, 8'h00);
        repeat (3) @(negedge core_clk);
        chk({7'h0, selected}, 8'h01);
        chk({6'h0, mode}, {6'h0, DRDEC_MODE_NORMAL});
        chk({6'h0, dmarq_oe, dmarq_out}, 8'h03);
        // Sleep without the reset command
        in_sleep = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({6'h0, mode}, {6'h0, DRDEC_MODE_SLEEP_NR});
        chk({7'h0, dmarq_oe}, 8'h00);
        host.wr(2'b01, DRDEC_A_CYLLO, ~m[4]);
        chk(cyllo_reg, m[4]);
        host.rd(2'b10, DRDEC_A_DEVCTL, d, oe);
        chk({7'h0, oe}, 8'h00);
        for (int s = 0; s < 2; s++) begin
            e = n_wake;
            host.wr(2'b10, DRDEC_A_DEVCTL, 8'(s << 2));
            chk(8'(n_wake - e), 8'(s));
            chk({7'h0, devctl_reg[2]}, 8'(s));
        end
        // Sleep with the reset command
        reset_cmd_supported = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({6'h0, mode}, {6'h0, DRDEC_MODE_SLEEP_R});
        chk({7'h0, dmarq_oe}, 8'h00);
        for (int s = 0; s < 2; s++) begin
            e = n_exec;
            host.wr(2'b01, DRDEC_A_CMD, DRDEC_CMD_DRST);
            chk(8'(n_exec - e), 8'(1 - s));
            host.wr(2'b01, DRDEC_A_DEVHEAD, 8'h10);
            chk({7'h0, devhead_reg[4]}, 8'h01);
            chk({7'h0, selected}, 8'h00);
            host.rd(2'b01, 3'(6 + s), d, oe);
            chk({7'h0, oe}, 8'h00);
        end
        final_report();
    end
    initial begin
        #(5000 * 50);
        bad_count++;
        final_report();
    end
endmodule
